// >>> rtl/ctt_timer_triple.sv
// three down-counting timers with prescalers behind an AXI4-Lite slave
// Notes on behaviour
// RULE1: three identical timers, 32-bit counter and presettable period each.
// RULE2: 16-bit prescaler; count steps at clock rate over prescale value.
// RULE3: counter counts down, raises its interrupt on reaching zero.
// RULE4: on zero the counter reloads from the period automatically.
// RULE5: timer 2 interrupt drives cpu interrupt line fourteen.
// RULE6: timer 1 interrupt reaches line thirteen only when routed.
// RULE7: timer 0 interrupt feeds the peripheral interrupt expander.
// RULE8: registers reachable with 16-bit and 32-bit writes via strobes.
// RULE9: software avoids unmapped offsets; they answer with an error.
// RULE10: one request per zero event; reload on the same tick.
// RULE11: defined reset values; period write used at next reload.
`timescale 1ns/10ps
`include "ctt_defs.svh"
module ctt_timer_triple
#(
  parameter int NUM_TIMERS = 3
)
(
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // axi4-lite write
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output      logic                  s_axi_awready,
  input  wire ctt_pkg::ctt_word_type s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output      logic                  s_axi_wready,
  output      ctt_pkg::ctt_resp_type s_axi_bresp,
  output      logic                  s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output      logic                  s_axi_arready,
  output      ctt_pkg::ctt_word_type s_axi_rdata,
  output      ctt_pkg::ctt_resp_type s_axi_rresp,
  output      logic                  s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // interrupt lines
  output      logic                  peripheral_interrupt_expander,
  output      logic                  cpu_irq_line_thirteen,
  output      logic                  cpu_irq_line_fourteen
);
  import ctt_pkg::*;

  // timer state
  logic [31:0]    count_q [NUM_TIMERS],    count_d [NUM_TIMERS];
  logic [31:0]    period_q [NUM_TIMERS],   period_d [NUM_TIMERS];
  logic [15:0]    prescale_q [NUM_TIMERS], prescale_d [NUM_TIMERS];
  logic [15:0]    pre_cnt_q [NUM_TIMERS],  pre_cnt_d [NUM_TIMERS];
  logic [3:0]     ctrl_q [NUM_TIMERS],     ctrl_d [NUM_TIMERS];
  logic           route_q,                 route_d;
  logic [2:0]     irq_q,                   irq_d;

  // bus state
  ctt_wstate_type wstate_q,                wstate_d;
  logic           aw_hold_q,               aw_hold_d;
  logic           w_hold_q,                w_hold_d;
  logic [7:0]     awaddr_q,                awaddr_d;
  ctt_word_type   wdata_q,                 wdata_d;
  logic [3:0]     wstrb_q,                 wstrb_d;
  ctt_resp_type   bresp_q,                 bresp_d;
  logic           rvalid_q,                rvalid_d;
  ctt_word_type   rdata_q,                 rdata_d;
  ctt_resp_type   rresp_q,                 rresp_d;

  logic           do_write;
  logic [31:0]    wmask;

  // merges strobed bytes into a word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  assign do_write = (wstate_q == CTT_W_IDLE) && aw_hold_q && w_hold_q;
  assign wmask    = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                     {8{wstrb_q[1]}}, {8{wstrb_q[0]}}}; // RULE8

  // timer counting and register writes
  always_comb
  begin
    logic [NUM_TIMERS-1:0] zero_ev;
    logic [1:0]            t;
    logic                  sel;
    zero_ev = '0;
    t = 2'(awaddr_q[5:4]);
    sel = do_write && (awaddr_q[7:6] == 2'h0) && (t < 2'(NUM_TIMERS));
    route_d = route_q;
    for (int i = 0; i < NUM_TIMERS; i++)
    begin
      count_d[i]    = count_q[i];
      period_d[i]   = period_q[i];
      prescale_d[i] = prescale_q[i];
      pre_cnt_d[i]  = pre_cnt_q[i];
      ctrl_d[i]     = ctrl_q[i];
      irq_d[i]      = 1'b0;
      if (!ctrl_q[i][`CTT_CTRL_STOP])
      begin
        // prescaler of 0 or 1 ticks every clock
        if (pre_cnt_q[i] == 16'h0000) // RULE2
        begin
          pre_cnt_d[i] = (prescale_q[i] == 16'h0000) ? 16'h0000
                         : prescale_q[i] - 16'h0001; // RULE2
          zero_ev[i] = (count_q[i] <= 32'h00000001);
          if (zero_ev[i])
          begin
            count_d[i] = period_q[i]; // RULE4 RULE10 RULE11
            ctrl_d[i][`CTT_CTRL_FLAG] = 1'b1; // RULE3
            irq_d[i] = ctrl_q[i][`CTT_CTRL_IRQ_EN]; // RULE3 RULE10
          end
          else
            count_d[i] = count_q[i] - 32'h00000001; // RULE3
        end
        else
          pre_cnt_d[i] = pre_cnt_q[i] - 16'h0001;
      end
    end
    if (sel)
    begin
      case (awaddr_q[3:0])
        `CTT_OFF_PERIOD:
          period_d[t] = merge(period_q[t], wdata_q, wmask); // RULE1
        `CTT_OFF_PRESCALE:
          prescale_d[t] = 16'(merge({16'h0000, prescale_q[t]}, wdata_q,
                                    wmask));
        `CTT_OFF_CTRL:
          if (wstrb_q[0])
          begin
            ctrl_d[t][2:0] = wdata_q[2:0];
            // write one clears the flag, a fresh zero event wins
            if (wdata_q[`CTT_CTRL_FLAG] && !zero_ev[t])
              ctrl_d[t][`CTT_CTRL_FLAG] = 1'b0;
            if (wdata_q[`CTT_CTRL_RELOAD])
            begin
              count_d[t]   = period_d[t]; // RULE1
              pre_cnt_d[t] = prescale_q[t];
            end
            ctrl_d[t][`CTT_CTRL_RELOAD] = 1'b0;
          end
        default: ;
      endcase
    end
    else if (do_write && awaddr_q == `CTT_OFF_ROUTE && wstrb_q[0])
      route_d = wdata_q[`CTT_ROUTE_T1_EN]; // RULE6
  end

  // axi write channel
  always_comb
  begin
    logic ok;
    ok = (awaddr_q[1:0] == 2'h0) &&
         ((awaddr_q[7:6] == 2'h0 && awaddr_q[5:4] < 2'(NUM_TIMERS))
          || awaddr_q == `CTT_OFF_ROUTE);
    wstate_d  = wstate_q;
    aw_hold_d = aw_hold_q;
    w_hold_d  = w_hold_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bresp_d   = bresp_q;
    if (s_axi_awvalid && !aw_hold_q && wstate_q == CTT_W_IDLE)
    begin
      aw_hold_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_hold_q && wstate_q == CTT_W_IDLE)
    begin
      w_hold_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
    end
    case (wstate_q)
      CTT_W_IDLE:
        if (do_write)
        begin
          bresp_d   = ok ? `CTT_RESP_OKAY : `CTT_RESP_SLVERR; // RULE9
          wstate_d  = CTT_W_RESP;
          aw_hold_d = 1'b0;
          w_hold_d  = 1'b0;
        end
      CTT_W_RESP:
        if (s_axi_bready)
          wstate_d = CTT_W_IDLE;
      default:
        wstate_d = CTT_W_IDLE;
    endcase
  end

  // axi read channel
  always_comb
  begin
    logic [1:0] t;
    t = 2'(s_axi_araddr[5:4]);
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (rvalid_q && s_axi_rready)
      rvalid_d = 1'b0;
    else if (!rvalid_q && s_axi_arvalid)
    begin
      rvalid_d = 1'b1;
      rdata_d  = 32'h00000000;
      rresp_d  = `CTT_RESP_OKAY;
      if (s_axi_araddr[1:0] != 2'h0)
        rresp_d = `CTT_RESP_SLVERR; // RULE9
      else if (s_axi_araddr[7:6] == 2'h0 && t < 2'(NUM_TIMERS))
      begin
        case (s_axi_araddr[3:0])
          `CTT_OFF_COUNT:    rdata_d = count_q[t];
          `CTT_OFF_PERIOD:   rdata_d = period_q[t];
          `CTT_OFF_CTRL:     rdata_d = {28'h0000000, ctrl_q[t]};
          `CTT_OFF_PRESCALE: rdata_d = {16'h0000, prescale_q[t]};
          default:           rresp_d = `CTT_RESP_SLVERR;
        endcase
      end
      else if (s_axi_araddr == `CTT_OFF_ROUTE)
        rdata_d = {31'h00000000, route_q};
      else
        rresp_d = `CTT_RESP_SLVERR; // RULE9
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_q    <= '{default: `CTT_RST_PERIOD}; // RULE11
      period_q   <= '{default: `CTT_RST_PERIOD}; // RULE11
      prescale_q <= '{default: `CTT_RST_PRESCALE}; // RULE11
      pre_cnt_q  <= '{default: `CTT_RST_PRESCALE};
      ctrl_q     <= '{default: `CTT_RST_CTRL};
      route_q   <= 1'b0;
      irq_q     <= 3'h0;
      wstate_q  <= CTT_W_IDLE;
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
      bresp_q   <= `CTT_RESP_OKAY;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= `CTT_RESP_OKAY;
      peripheral_interrupt_expander <= 1'b0;
      cpu_irq_line_thirteen <= 1'b0;
      cpu_irq_line_fourteen <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
    else
    begin
      count_q    <= count_d;
      period_q   <= period_d;
      prescale_q <= prescale_d;
      pre_cnt_q  <= pre_cnt_d;
      ctrl_q     <= ctrl_d;
      route_q    <= route_d;
      irq_q      <= irq_d;
      wstate_q   <= wstate_d;
      aw_hold_q  <= aw_hold_d;
      w_hold_q   <= w_hold_d;
      awaddr_q   <= awaddr_d;
      wdata_q    <= wdata_d;
      wstrb_q    <= wstrb_d;
      bresp_q    <= bresp_d;
      rvalid_q   <= rvalid_d;
      rdata_q    <= rdata_d;
      rresp_q    <= rresp_d;
      peripheral_interrupt_expander <= irq_q[0]; // RULE7
      cpu_irq_line_thirteen <= irq_q[1] & route_q; // RULE6
      cpu_irq_line_fourteen <= irq_q[2]; // RULE5
      s_axi_awready <= s_axi_awvalid && !aw_hold_q && !s_axi_awready
                       && wstate_q == CTT_W_IDLE;
      s_axi_wready  <= s_axi_wvalid && !w_hold_q && !s_axi_wready
                       && wstate_q == CTT_W_IDLE;
      s_axi_bvalid  <= (wstate_d == CTT_W_RESP);
      s_axi_arready <= !rvalid_d;
    end
  end

  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
endmodule

// >>> shared/ctt_defs.svh
// register offsets, field positions and reset values of the timer block
`ifndef CTT_DEFS_SVH
`define CTT_DEFS_SVH
// per-timer window: timer n at n * CTT_TMR_STRIDE
`define CTT_TMR_STRIDE   8'h10
`define CTT_OFF_COUNT    4'h0
`define CTT_OFF_PERIOD   4'h4
`define CTT_OFF_CTRL     4'h8
`define CTT_OFF_PRESCALE 4'hC
`define CTT_OFF_ROUTE    8'h30
// control fields
`define CTT_CTRL_STOP    0
`define CTT_CTRL_RELOAD  1
`define CTT_CTRL_IRQ_EN  2
`define CTT_CTRL_FLAG    3
// route register field
`define CTT_ROUTE_T1_EN  0
// reset values and response codes
`define CTT_RST_PERIOD   32'hFFFFFFFF
`define CTT_RST_PRESCALE 16'h0000
`define CTT_RST_CTRL     4'h0
`define CTT_RESP_OKAY    2'h0
`define CTT_RESP_SLVERR  2'h2
`endif

// >>> shared/ctt_pkg.sv
// types shared by the timer block
package ctt_pkg;
  typedef logic [31:0] ctt_word_type;
  typedef logic [1:0]  ctt_resp_type;
  typedef enum logic [1:0] {CTT_W_IDLE, CTT_W_RESP} ctt_wstate_type;
endpackage

// >>> testbench/ctt_irq_sink.sv
// partner model: interrupt receiver counting pulses and spacing
`timescale 1ns/10ps
module ctt_irq_sink (
  // clock and reset
  input logic              aclk,
  input logic              aresetn,
  // interrupt lines
  input logic              peripheral_interrupt_expander,
  input logic              cpu_irq_line_thirteen,
  input logic              cpu_irq_line_fourteen,
  // pulse count and last spacing per line
  output logic [2:0][15:0] cnt_q,
  output logic [2:0][15:0] gap_q
);
  logic [2:0]       irq;
  logic [15:0]      cyc_q;
  logic [2:0][15:0] last_q;
  assign irq = {cpu_irq_line_fourteen, cpu_irq_line_thirteen,
                peripheral_interrupt_expander};
  always_ff @(posedge aclk)
  begin
    cyc_q <= aresetn ? cyc_q + 16'h1 : 16'h0;
    for (int i = 0; i < 3; i++)
    begin
      if (!aresetn)
        cnt_q[i] <= 16'h0;
      else if (irq[i])
      begin
        cnt_q[i] <= cnt_q[i] + 16'h1;
        gap_q[i] <= cyc_q - last_q[i];
        last_q[i] <= cyc_q;
      end
    end
  end
endmodule

// >>> testbench/ctt_timer_triple_chk.sv
// port checker of the triple timer
`timescale 1ns/10ps
module ctt_timer_triple_chk (
  input logic        aclk,
  input logic        aresetn,
  input logic        s_axi_awready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  input logic        peripheral_interrupt_expander,
  input logic        cpu_irq_line_thirteen,
  input logic        cpu_irq_line_fourteen
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_pie_pulse: assert property (
    peripheral_interrupt_expander |=> !peripheral_interrupt_expander)
    else $error("pie line pulse too long");
  chk_l13_pulse: assert property (
    cpu_irq_line_thirteen |=> !cpu_irq_line_thirteen)
    else $error("line thirteen pulse too long");
  chk_l14_pulse: assert property (
    cpu_irq_line_fourteen |=> !cpu_irq_line_fourteen)
    else $error("line fourteen pulse too long");
  chk_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_r_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_err_zero: assert property (
    s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("refused read returned data");
  chk_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  chk_wr_answer: assert property (
    $rose(s_axi_awready) |-> ##[1:3] s_axi_bvalid)
    else $error("write not answered");
  chk_aw_once: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held");
endmodule
bind ctt_timer_triple ctt_timer_triple_chk chk_u (.aclk, .aresetn,
  .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .s_axi_rresp, .peripheral_interrupt_expander,
  .cpu_irq_line_thirteen, .cpu_irq_line_fourteen);

// >>> testbench/ctt_timer_triple_tb.sv
// self-checking bench of the triple timer
`timescale 1ns/10ps
`define CHK(n, e, g) cmp(n, e, g)
module ctt_timer_triple_tb;
  import ctt_pkg::*;
  typedef struct {logic [7:0] a; ctt_word_type d; logic [3:0] s;
                  bit w; ctt_resp_type r; ctt_word_type q;} ctt_row_type;
  logic             aclk, aresetn, s_axi_awvalid, s_axi_wvalid;
  logic             s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic             s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic             s_axi_arready, s_axi_rvalid;
  logic             peripheral_interrupt_expander;
  logic             cpu_irq_line_thirteen, cpu_irq_line_fourteen;
  logic [7:0]       s_axi_awaddr, s_axi_araddr;
  logic [3:0]       s_axi_wstrb;
  ctt_word_type     s_axi_wdata, s_axi_rdata, q, c1;
  ctt_resp_type     s_axi_bresp, s_axi_rresp;
  logic [2:0][15:0] cnt_q, gap_q;
  int               fails, total_checks;
  int               per_t [3] = '{4, 5, 7};
  int               pre_t [3] = '{2, 3, 1};
  ctt_row_type rows [9] = '{
    '{8'h04, 32'h0, 4'h0, 0, 2'h0, 32'hFFFFFFFF},
    '{8'h08, 32'h0, 4'h0, 0, 2'h0, 32'h0},
    '{8'h0C, 32'h0, 4'h0, 0, 2'h0, 32'h0},
    '{8'h30, 32'h0, 4'h0, 0, 2'h0, 32'h0},
    '{8'h14, 32'h00001234, 4'h3, 1, 2'h0, 32'hFFFF1234},
    '{8'h24, 32'hABCD0000, 4'hC, 1, 2'h0, 32'hABCDFFFF},
    '{8'h0C, 32'hFFFFFFFF, 4'hF, 1, 2'h0, 32'h0000FFFF},
    '{8'h3C, 32'h1, 4'hF, 1, 2'h2, 32'h0},
    '{8'h05, 32'h0, 4'h0, 0, 2'h2, 32'h0}};
  ctt_timer_triple #(.NUM_TIMERS(3)) dut_u (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .peripheral_interrupt_expander,
    .cpu_irq_line_thirteen, .cpu_irq_line_fourteen);
  ctt_irq_sink sink_u (.aclk, .aresetn, .peripheral_interrupt_expander,
    .cpu_irq_line_thirteen, .cpu_irq_line_fourteen, .cnt_q, .gap_q);
  task automatic cmp(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic hang(input int t);
    if (t >= 300)
    begin
      fails++;
      wrap_up();
    end
  endtask
  // write; bready raised only once bvalid is seen
  task automatic wr(input logic [7:0] a, input ctt_word_type d,
                    input logic [3:0] s, input ctt_resp_type r);
    int t;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (t = 0; t < 300; t++)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
        break;
      s_axi_bready <= s_axi_bvalid;
    end
    hang(t);
    `CHK("bresp", r, s_axi_bresp);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output ctt_word_type d,
                    input ctt_resp_type r);
    int t;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (t = 0; t < 300; t++)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready)
        break;
      s_axi_rready <= s_axi_rvalid;
    end
    hang(t);
    d = s_axi_rdata;
    `CHK("rresp", r, s_axi_rresp);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic wait_irq(input int n, input int k);
    int t;
    for (t = 0; t < 300 && cnt_q[n] < k; t++)
      @(posedge aclk);
    hang(t);
  endtask
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial
  begin
    {fails, total_checks} = 0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 0;
    {s_axi_wdata, s_axi_wstrb} = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rows[i])
    begin
      if (rows[i].w)
        wr(rows[i].a, rows[i].d, rows[i].s, 2'(rows[i].r));
      rd(rows[i].a, q, rows[i].r);
      `CHK("reg", rows[i].q, q);
    end
    $display("test registers done");
    for (int n = 0; n < 3; n++)
    begin
      wr(8'(n * 16 + 4), per_t[n], 4'hF, 2'h0);
      wr(8'(n * 16 + 12), pre_t[n], 4'hF, 2'h0);
      wr(8'(n * 16 + 8), 32'h6, 4'hF, 2'h0);
    end
    wait_irq(0, cnt_q[0] + 8);
    `CHK("unrouted", 32'h0, cnt_q[1]);
    wr(8'h30, 32'h1, 4'h1, 2'h0);
    for (int n = 0; n < 3; n++)
    begin
      wait_irq(n, cnt_q[n] + 2);
      `CHK("gap", per_t[n] * pre_t[n], gap_q[n]);
    end
    rd(8'h08, q, 2'h0);
    `CHK("zero flag", 32'hC, q);
    $display("test periodic interrupts done");
    wr(8'h24, 32'h3, 4'hF, 2'h0);
    wait_irq(2, cnt_q[2] + 2);
    `CHK("new period", 32'h3, gap_q[2]);
    wr(8'h04, 32'h100, 4'hF, 2'h0);
    wr(8'h08, 32'h3, 4'hF, 2'h0);
    rd(8'h00, c1, 2'h0);
    `CHK("loaded", 32'h100, c1);
    wr(8'h08, 32'h0, 4'hF, 2'h0);
    rd(8'h00, c1, 2'h0);
    rd(8'h00, q, 2'h0);
    `CHK("down", 1'b1, q < c1 && c1 < 32'h100);
    $display("test period and count done");
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h24, q, 2'h0);
    `CHK("reset period", 32'hFFFFFFFF, q);
    rd(8'h28, q, 2'h0);
    `CHK("reset ctrl", 32'h0, q);
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule
